/* File: hw/ctp_defs.vh */
// constants for the cascaded 16-bit timer, pwm and pulse generator
// Function
// - low and high counters chain into one 16-bit up-counter with 16-bit compare
// - timer mode: count internal clock, on match interrupt, clear, keep counting
// - counting starts when run-start bit written 1, clearing it stops counting
// - timer and event modes: compare unbuffered, takes effect right after write
// - event mode: count event pin falling edges, match interrupts and clears
// - pwm: duty match toggles output, overflow toggles, clears, interrupts
// - pwm duty written while running goes via shadow, loaded at interrupt
// - pwm duty reads return active value until next interrupt
// - pwm and pulse modes start flip-flop from initial bit; reset clears it
// - pwm and pulse pins drive inverse of output flip-flop
// - stopping holds output level; level changed only by later flip-flop write
// - pulse mode: duty match toggles, period match toggles, clears, interrupts
// - pulse mode registers unbuffered; software keeps them still while running
// - counter clock is one of four prescaled taps, divider setting halves rate
`ifndef CTP_DEFS_VH
`define CTP_DEFS_VH

// register byte addresses on the bus
`define CTP_OFS_PERIOD_LO  8'h00
`define CTP_OFS_PERIOD_HI  8'h04
`define CTP_OFS_DUTY_LO    8'h08
`define CTP_OFS_DUTY_HI    8'h0C
`define CTP_OFS_LOW_CTRL   8'h10
`define CTP_OFS_HIGH_CTRL  8'h14
`define CTP_OFS_STATUS     8'h18

// low_channel_control fields
`define CTP_LC_MODE_LSB    0
`define CTP_LC_MODE_MSB    1
`define CTP_LC_TAP_LSB     2
`define CTP_LC_TAP_MSB     3
`define CTP_LC_EXT_BIT     4
`define CTP_LC_DIV_BIT     5
`define CTP_LC_RESET       8'h00

// high_channel_control fields
`define CTP_HC_RUN_BIT     0
`define CTP_HC_FF_BIT      1
`define CTP_HC_RESET       8'h00

// status fields
`define CTP_ST_FF_BIT      16
`define CTP_ST_RUN_BIT     17

// modes
`define CTP_MODE_TIMER     2'h0
`define CTP_MODE_EVENT     2'h1
`define CTP_MODE_PWM       2'h2
`define CTP_MODE_PPG       2'h3

// timing: finest resolution 0.4 us at 20 MHz gives 8 cycles, a shift of 3
`define CTP_CLK_KHZ        20000
`define CTP_RES_MIN_PS     400000
`define CTP_RES_MIN_CYC    ((`CTP_RES_MIN_PS / 1000) * `CTP_CLK_KHZ / 1000000)
`define CTP_TAP0_SHIFT     4'h3
`define CTP_TAP1_SHIFT     4'h5
`define CTP_TAP2_SHIFT     4'h7
`define CTP_TAP3_SHIFT     4'hB
`define CTP_PRE_W          13

`endif

/* File: hw/ctp_prescaler.v */
// prescaler producing one-cycle ticks at the selected divided system clock rate
`timescale 1ns/1ps
`include "ctp_defs.vh"

module ctp_prescaler (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [1:0] tap_sel,
  input  wire       div_sel,
  output reg        tick_r
);

  reg  [`CTP_PRE_W-1:0] cnt_r;
  wire [`CTP_PRE_W-1:0] ones;
  reg  [3:0]            shift;
  wire [`CTP_PRE_W:0]   cnt_inc;

  assign cnt_inc = {1'b0, cnt_r} + {{`CTP_PRE_W{1'b0}}, 1'b1};

  // ones[i] is high when all counter bits 0..i are set
  genvar gi;
  generate
    for (gi = 0; gi < `CTP_PRE_W; gi = gi + 1) begin : g_ones
      if (gi == 0) begin : g_first
        assign ones[gi] = cnt_r[0];
      end else begin : g_rest
        assign ones[gi] = ones[gi-1] & cnt_r[gi];
      end
    end
  endgenerate

  // tap choice; divider setting adds one stage and so halves the rate
  always @* begin
    case (tap_sel)
      2'h0:    shift = `CTP_TAP3_SHIFT;
      2'h1:    shift = `CTP_TAP2_SHIFT;
      2'h2:    shift = `CTP_TAP1_SHIFT;
      default: shift = `CTP_TAP0_SHIFT;
    endcase
    if (div_sel) begin
      shift = shift + 4'h1;
    end
  end

  // free-running divider; the tick lands once per 2^shift cycles
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r  <= {`CTP_PRE_W{1'b0}};
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_inc[`CTP_PRE_W-1:0];
      tick_r <= ones[shift - 4'h1];
    end
  end

endmodule

/* File: hw/ctp_timer.v */
// cascaded 16-bit timer, event counter, pwm and pulse generator with AXI4-Lite slave
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ctp_defs.vh"

module ctp_timer (
  input  wire        clk,
  input  wire        sys_rst,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pins and interrupt
  input  wire        event_input_pin,
  output reg         pwm_output_pin,
  output reg         pulse_generator_output_pin,
  output reg         match_overflow_interrupt
);

  localparam [1:0] RESP_OKAY   = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;

  // bus-side holding registers
  reg [7:0]  awaddr_r;
  reg        aw_full_r;
  reg [7:0]  wdata_r;
  reg        wstrb0_r;
  reg        w_full_r;
  reg [7:0]  araddr_r;
  reg        ar_full_r;

  // software-visible state
  reg [15:0] period_r;
  reg [15:0] duty_shadow_r;
  reg [15:0] duty_act_r;
  reg [7:0]  low_ctrl_r;
  reg [7:0]  high_ctrl_r;

  // counting state
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;
  reg        flip;
  reg        wrap;
  reg        out_r;          // output toggle flip-flop

  // event pin synchroniser and debounced level
  reg        evt_s1_r;
  reg        evt_s2_r;
  reg        evt_s3_r;
  reg        evt_lvl_r;
  wire       evt_fall;

  wire       tick;
  wire [1:0] mode;
  wire       run;
  wire       use_event;
  wire       step;
  wire [16:0] inc_full;
  wire [15:0] inc;

  // write path decode
  wire       wr_fire;
  wire       wr_ok;
  wire       wr_en;
  reg        rd_ok;
  reg [31:0] rd_val;

  assign mode      = low_ctrl_r[`CTP_LC_MODE_MSB:`CTP_LC_MODE_LSB];
  assign run       = high_ctrl_r[`CTP_HC_RUN_BIT];
  assign inc_full  = {1'b0, cnt_r} + 17'h00001;
  assign inc       = inc_full[15:0];
  assign wr_fire   = aw_full_r & w_full_r & ~s_axi_bvalid;
  assign wr_ok     = (awaddr_r <= `CTP_OFS_STATUS) && (awaddr_r[1:0] == 2'h0);
  assign wr_en     = wr_fire & wr_ok & wstrb0_r;

  ctp_prescaler u_pre (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tap_sel (low_ctrl_r[`CTP_LC_TAP_MSB:`CTP_LC_TAP_LSB]),
    .div_sel (low_ctrl_r[`CTP_LC_DIV_BIT]),
    .tick_r  (tick)
  );

  // three flops on the pin; a new level counts only when stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      evt_s1_r  <= 1'b1;
      evt_s2_r  <= 1'b1;
      evt_s3_r  <= 1'b1;
      evt_lvl_r <= 1'b1;
    end else begin
      evt_s1_r <= event_input_pin;
      evt_s2_r <= evt_s1_r;
      evt_s3_r <= evt_s2_r;
      if (evt_s2_r == evt_s3_r) begin
        evt_lvl_r <= evt_s3_r;
      end
    end
  end

  // falling edge of the filtered event level
  assign evt_fall  = evt_lvl_r & ~evt_s2_r & ~evt_s3_r;

  // event mode always counts pin edges; pwm and pulse modes may choose them
  assign use_event = (mode == `CTP_MODE_EVENT) |
                     (((mode == `CTP_MODE_PWM) | (mode == `CTP_MODE_PPG)) & low_ctrl_r[`CTP_LC_EXT_BIT]);
  assign step      = run & (use_event ? evt_fall : tick);

  // next count, toggle and wrap for the selected mode
  always @* begin
    cnt_nxt = cnt_r;
    flip    = 1'b0;
    wrap    = 1'b0;
    if (!run) begin
      cnt_nxt = 16'h0000;
    end else if (step) begin
      cnt_nxt = inc;
      case (mode)
        `CTP_MODE_TIMER, `CTP_MODE_EVENT: begin
          if (inc == period_r) begin
            wrap = 1'b1;
          end
        end
        `CTP_MODE_PWM: begin
          if (cnt_r == 16'hFFFF) begin
            wrap = 1'b1;
            flip = 1'b1;
          end else if (inc == duty_act_r) begin
            flip = 1'b1;
          end
        end
        `CTP_MODE_PPG: begin
          if (inc == duty_act_r) begin
            flip = 1'b1;
          end
          if (inc == period_r) begin
            wrap = 1'b1;
            flip = ~flip;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
    if (wrap) begin
      cnt_nxt = 16'h0000;
    end
  end

  // counter, output flip-flop, interrupt pulse and pins
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r                      <= 16'h0000;
      out_r                      <= 1'b0;
      match_overflow_interrupt   <= 1'b0;
      pwm_output_pin             <= 1'b1;
      pulse_generator_output_pin <= 1'b1;
    end else begin
      cnt_r                    <= cnt_nxt;
      match_overflow_interrupt <= wrap;
      if (wr_en && (awaddr_r == `CTP_OFS_HIGH_CTRL) && !run) begin
        // a stopped counter takes the initial level, both on start and while idle;
        // the write that stops a running counter leaves the level alone
        out_r                      <= wdata_r[`CTP_HC_FF_BIT];
        pwm_output_pin             <= ~wdata_r[`CTP_HC_FF_BIT];
        pulse_generator_output_pin <= ~wdata_r[`CTP_HC_FF_BIT];
      end else if (flip) begin
        out_r                      <= ~out_r;
        pwm_output_pin             <= out_r;
        pulse_generator_output_pin <= out_r;
      end
    end
  end

  // register writes and duty double buffering
  always @(posedge clk) begin
    if (sys_rst) begin
      period_r      <= 16'h0000;
      duty_shadow_r <= 16'h0000;
      duty_act_r    <= 16'h0000;
      low_ctrl_r    <= `CTP_LC_RESET;
      high_ctrl_r   <= `CTP_HC_RESET;
    end else begin
      if (wrap && (mode == `CTP_MODE_PWM)) begin
        duty_act_r <= duty_shadow_r;
      end
      if (wr_en) begin
        case (awaddr_r)
          `CTP_OFS_PERIOD_LO: period_r[7:0]  <= wdata_r;
          `CTP_OFS_PERIOD_HI: period_r[15:8] <= wdata_r;
          `CTP_OFS_DUTY_LO: begin
            duty_shadow_r[7:0] <= wdata_r;
            if (!(run && mode == `CTP_MODE_PWM)) begin
              duty_act_r[7:0] <= wdata_r;
            end
          end
          `CTP_OFS_DUTY_HI: begin
            duty_shadow_r[15:8] <= wdata_r;
            if (!(run && mode == `CTP_MODE_PWM)) begin
              duty_act_r[15:8] <= wdata_r;
            end
          end
          `CTP_OFS_LOW_CTRL:  low_ctrl_r  <= wdata_r;
          `CTP_OFS_HIGH_CTRL: high_ctrl_r <= wdata_r;
          default: begin
            low_ctrl_r <= low_ctrl_r;
          end
        endcase
      end
    end
  end

  // read mux; duty reads show the active value, not the pending one
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (araddr_r)
      `CTP_OFS_PERIOD_LO: rd_val[7:0] = period_r[7:0];
      `CTP_OFS_PERIOD_HI: rd_val[7:0] = period_r[15:8];
      `CTP_OFS_DUTY_LO:   rd_val[7:0] = duty_act_r[7:0];
      `CTP_OFS_DUTY_HI:   rd_val[7:0] = duty_act_r[15:8];
      `CTP_OFS_LOW_CTRL:  rd_val[7:0] = low_ctrl_r;
      `CTP_OFS_HIGH_CTRL: rd_val[7:0] = high_ctrl_r;
      `CTP_OFS_STATUS: begin
        rd_val[15:0]            = cnt_r;
        rd_val[`CTP_ST_FF_BIT]  = out_r;
        rd_val[`CTP_ST_RUN_BIT] = run;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // write channels: each ready is a one-cycle pulse after its valid is seen,
  // the address and data are latched on the next edge, at the handshake, since the master holds them
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_r      <= 8'h00;
      aw_full_r     <= 1'b0;
      wdata_r       <= 8'h00;
      wstrb0_r      <= 1'b0;
      w_full_r      <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_full_r & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~w_full_r & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r  <= s_axi_awaddr;
        aw_full_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
        w_full_r <= 1'b1;
      end
      if (wr_fire) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: address pulse, then data one cycle after the handshake
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
      araddr_r      <= 8'h00;
      ar_full_r     <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~ar_full_r & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_r  <= s_axi_araddr;
        ar_full_r <= 1'b1;
      end
      if (ar_full_r && !s_axi_rvalid) begin
        ar_full_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: sim/ctp_timer_asserts.sv */
// port-level assertion checker for the cascaded timer
`timescale 1ns/1ps
module ctp_timer_asserts (
  input wire        clk,
  input wire        sys_rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        pwm_output_pin,
  input wire        pulse_generator_output_pin,
  input wire        match_overflow_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // both handshakes of a write, and the read address handshake
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_pins_match: assert property (
    pwm_output_pin == pulse_generator_output_pin) else $error("output pins differ");
  chk_irq_pulse: assert property (
    match_overflow_interrupt |=> !match_overflow_interrupt) else $error("interrupt wider than one cycle");
  // reset must be visible even though other checks are disabled meanwhile
  chk_reset_pin: assert property (
    disable iff (1'b0) sys_rst |=> pwm_output_pin && !match_overflow_interrupt) else $error("reset state wrong");
  chk_write_answer: assert property (
    s_wr |-> ##2 s_axi_bvalid) else $error("write response not on time");
  chk_read_answer: assert property (
    s_rd |-> ##2 s_axi_rvalid) else $error("read data not on time");
  chk_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_data_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ready_pulse: assert property (
    (s_axi_awready |=> !s_axi_awready) and (s_axi_arready |=> !s_axi_arready)) else $error("ready not a pulse");
endmodule

bind ctp_timer ctp_timer_asserts u_chk (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pwm_output_pin, .pulse_generator_output_pin, .match_overflow_interrupt);

/* File: sim/ctp_event_src.sv */
// external event pulse source driving the event input pin
`timescale 1ns/1ps
module ctp_event_src (
  input  wire       clk,
  input  wire       go,
  input  wire [7:0] edges,
  output reg        pin,
  output reg        busy
);
  reg [7:0] left_r;
  reg [2:0] cnt_r;

  initial begin
    pin = 1'b1;
    busy = 1'b0;
    left_r = 8'h00;
    cnt_r = 3'h0;
  end

  // the 3-bit count wraps, so each level lasts eight cycles: a sixteenth of the clock at most
  always @(posedge clk) begin
    if (go) begin
      left_r <= edges;
      busy <= 1'b1;
      cnt_r <= 3'h0;
    end else if (busy) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h3) begin
        pin <= ~pin;
        if (pin)
          left_r <= left_r - 8'h01;
        else if (left_r == 8'h00)
          busy <= 1'b0; // ends idle high
      end
    end
  end
endmodule

/* File: sim/ctp_timer_test.sv */
// self-checking bench for the cascaded timer
`timescale 1ns/1ps
module ctp_timer_test;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, event_input_pin;
  logic        pwm_output_pin, pulse_generator_output_pin, match_overflow_interrupt, ev_go, ev_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ev_edges;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails, checks, n, d, k, irqs;

  ctp_timer dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_input_pin,
    .pwm_output_pin, .pulse_generator_output_pin, .match_overflow_interrupt);
  ctp_event_src src (.clk, .go(ev_go), .edges(ev_edges), .pin(event_input_pin), .busy(ev_busy));

  // clock and interrupt tally
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (match_overflow_interrupt === 1'b1) irqs++;

  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a spent bound counts as a mismatch and closes the run
  task automatic lim(input int c, input int m);
    if (c >= m) begin
      chk(c, m + 1);
      end_of_test;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dt, input logic [1:0] e = 2'h0);
    int c;
    c = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      c++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && c < 50);
    lim(c, 50);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e = 2'h0);
    int c;
    c = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      c++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && c < 50);
    lim(c, 50);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, x);
    chk(s_axi_rresp, e);
  endtask

  // wait for pin level 0 or 1, interrupt (2) or source idle (3)
  task automatic waitc(input logic [1:0] s, output int c);
    logic t;
    c = 0;
    do begin
      @(posedge clk);
      c++;
      t = (s == 2'h2) ? match_overflow_interrupt : (s == 2'h3) ? !ev_busy : (pwm_output_pin === s[0]);
    end while (t !== 1'b1 && c < 12000);
    lim(c, 12000);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ev_go} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, ev_edges, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 7; k++) rd(8'(k * 4), 32'h0);
    chk(pwm_output_pin, 32'h1);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 8'hFF, 2'h2);
    // status ignores writes, and a write with byte lane 0 off changes nothing
    wr(8'h18, 8'hFF);
    s_axi_wstrb <= 4'h0;
    wr(8'h00, 8'hAA);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    // timer with a 16-bit period, both divider settings
    for (d = 0; d < 2; d++) begin
      wr(8'h00, 8'h02);
      wr(8'h04, 8'h01);
      wr(8'h10, 8'h0C | 8'(d << 5));
      wr(8'h14, 8'h01);
      waitc(2'h2, n);
      waitc(2'h2, n);
      chk(n, 32'd2064 << d);
      wr(8'h14, 8'h00);
    end
    // event counter, period four falling edges
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h01);
    k = irqs;
    ev_edges <= 8'h03;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    waitc(2'h3, n);
    rd(8'h18, 32'h0002_0003);
    ev_edges <= 8'h01;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    waitc(2'h3, n);
    chk(irqs - k, 32'h1);
    rd(8'h18, 32'h0002_0000);
    wr(8'h14, 8'h00);
    // pwm: polarity, shadowed duty, stop holding level
    wr(8'h10, 8'h0E);
    wr(8'h14, 8'h02);
    chk(pwm_output_pin, 32'h0);
    wr(8'h14, 8'h00);
    chk(pwm_output_pin, 32'h1);
    wr(8'h08, 8'h02);
    wr(8'h0C, 8'h00);
    rd(8'h08, 32'h02);
    wr(8'h14, 8'h01);
    waitc(2'h0, n);
    wr(8'h08, 8'h05);
    rd(8'h08, 32'h02);
    wr(8'h14, 8'h00);
    repeat (20) @(posedge clk);
    chk(pwm_output_pin, 32'h0);
    wr(8'h14, 8'h00);
    chk(pwm_output_pin, 32'h1);
    wr(8'h08, 8'h07);
    rd(8'h08, 32'h07);
    // pulse generator: duty 2, period 5 ticks of 8 cycles
    wr(8'h10, 8'h0F);
    wr(8'h00, 8'h05);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h02);
    wr(8'h0C, 8'h00);
    wr(8'h14, 8'h01);
    waitc(2'h2, n);
    waitc(2'h2, n);
    chk(n, 32'd40);
    waitc(2'h0, n);
    waitc(2'h1, n);
    chk(n, 32'd24);
    wr(8'h14, 8'h00);
    // pulse generator clocked by event pin edges: five falls make one full period
    wr(8'h10, 8'h1F);
    wr(8'h14, 8'h01);
    k = irqs;
    ev_edges <= 8'h05;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    waitc(2'h3, n);
    chk(irqs - k, 32'h1);
    rd(8'h18, 32'h0002_0000);
    chk(pulse_generator_output_pin, 32'h1);
    wr(8'h14, 8'h00);
    end_of_test;
  end
endmodule
